// ### e1rse_top.sv
/*
 * e1rse_top: receive E1 signaling extraction behind the elastic buffer.
 * Assumes line_data is already aligned to the system receive highway and
 * clocked by system_rx_clock; system_rx_sync_pulse marks bit 1 of slot 0.
 * Control and status bits are plain ports; highway controls, spare select and X bits use system_rx_clock, the rest core_clk.
 */
`timescale 1ns/1ps
// Contract
// - signaling is taken from time slot 16 of each received frame
// - sample line stream, or system stream when highway pin and enable set
// - serial highway carries signaling in last four bits of each slot except slot 0
// - first four bits optionally forced; slot 16 bits one to four are zero
// - slot 0 carries alignment word, slot 16 carries 0000XYXX
// - send-all-ones forces ones on data output and signaling highway
// - find signaling multiframe, detect AIS and remote alarm, split spare bits
// - freeze on loss of signal, multiframe alignment loss or slip
// - freeze status on a dedicated output and a status bit
// - auto-freeze disable bit suppresses automatic freeze
// - resync interrupt raised; software waits one multiframe before reading
// - processor mode stores sixteen signaling registers at multiframe boundary
// - registers hold last completed multiframe until replaced
// - no register update while freeze is active
// - change interrupt only when signaling differs between multiframes
// - change pointers mark exactly which registers changed
// - extractor works on system side of elastic buffer; slips corrupt it
// - selected spare bits go to the channel-1 receive fifo
// - five spare-bit registers each hold one bit over a multiframe
// - frame is 256 bits, 32 slots of 8 bits
// - slot numbering unchanged between line and system highway
// - bit 2 of non-alignment slot 0 is fixed one for sync
// - positive and negative slips reported separately, feed freeze
module e1rse_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic system_rx_clock,
    input wire logic link_rst,
    input wire logic system_rx_sync_pulse,
    input wire logic line_data,
    input wire logic system_side_data,
    input wire logic [1:0] port_function_cfg,
    input wire logic ext_signaling_enable,
    input wire logic [1:0] sig_upper_nibble_fill,
    input wire logic send_all_ones_system,
    input wire logic auto_freeze_disable,
    input wire logic loss_of_signal_flag,
    input wire logic slip_positive,
    input wire logic slip_negative,
    input wire logic [4:0] spare_bit_select,
    output logic system_rx_data_out,
    output logic sig_highway_out,
    output logic freeze_port,
    output logic freeze_status_bit,
    output logic sig_multiframe_align_lost,
    output logic sig_ais_detect,
    output logic sig_remote_alarm,
    output logic [2:0] sig_spare_x_bits,
    output logic [63:0] rx_signaling_regs,
    output logic [15:0] sig_change_pointer_regs,
    output logic signaling_change_irq,
    output logic resync_irq,
    output logic positive_slip_irq,
    output logic negative_slip_irq,
    output logic [7:0] rx_service_word_reg,
    output logic [79:0] spare_bit_regs,
    output logic [7:0] hdlc1_rx_fifo_data,
    output logic hdlc1_rx_fifo_valid
);
    // link-domain state: bit/slot/frame counters and assembly of one multiframe
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [4:0] slot;
        logic [3:0] frame;
        logic mf_sync;
        logic [2:0] mf_err;
        logic [7:0] shift;
        logic [7:0] ts0_word;
        logic [7:0] ts16_word;
        logic [63:0] mf_sig;
        logic [63:0] hw_sig;
        logic [79:0] spare_acc;
        logic fas_frame;
        logic [3:0] ais_zeros;
        logic mf_done;
        logic [7:0] fifo_byte;
        logic [2:0] fifo_cnt;
        logic fifo_push;
        logic sig_out;
        logic data_out;
        logic [2:0] x_bits;
        logic remote;
        logic ais;
    } e1rse_link_t;

    typedef struct packed {
        logic freeze;
        logic was_lost;
        logic [63:0] regs;
        logic [15:0] ptr;
        logic chg_irq;
        logic rs_irq;
        logic ps_irq;
        logic ns_irq;
        logic slip_seen;
        logic [79:0] spare;
        logic [7:0] fifo_data;
        logic fifo_valid;
        logic [7:0] svc;
    } e1rse_core_t;

    e1rse_link_t l;
    e1rse_link_t next_l;
    e1rse_core_t c;
    e1rse_core_t next_c;

    logic [1:0] pin_sync;
    logic sync_pulse_s;
    logic sys_data_s;
    logic line_s;
    logic in_bit;
    logic [4:0] cfg_link;
    logic mf_done_core;
    logic fifo_push_core;
    logic [4:0] status_core;
    logic [1:0] slip_s;
    logic los_s;
    logic [4:0] spare_sel_link;

    // link pins pass two flops before use
    e1rse_sync #(.W(2)) u_pin_sync (
        .clk(system_rx_clock),
        .rst(link_rst),
        .d({line_data, system_side_data}),
        .q(pin_sync)
    );
    e1rse_sync #(.W(1)) u_sp_sync (
        .clk(system_rx_clock),
        .rst(link_rst),
        .d(system_rx_sync_pulse),
        .q(sync_pulse_s)
    );
    // quasi-static configuration crosses as levels
    e1rse_sync #(.W(5)) u_cfg_sync (
        .clk(system_rx_clock),
        .rst(link_rst),
        .d({send_all_ones_system, sig_upper_nibble_fill,
            (port_function_cfg == e1rse_pkg::PCFG_SIG_HIGHWAY) && ext_signaling_enable,
            1'b0}),
        .q(cfg_link)
    );
    assign line_s = pin_sync[1];
    assign sys_data_s = pin_sync[0];
    // system stream only with highway pin function and enable both set
    assign in_bit = cfg_link[1] ? sys_data_s : line_s;

    always_comb begin
        logic [7:0] word;
        logic [5:0] sel_idx;
        word = {l.shift[6:0], in_bit};
        sel_idx = '0;
        next_l = l;
        next_l.mf_done = 1'b0;
        next_l.fifo_push = 1'b0;
        next_l.shift = word;
        // 256-bit frame as 32 slots of 8 bits, numbering kept as received
        if (sync_pulse_s) begin
            // pulse rides on bit 1 of slot 0, so the next bit is the second
            next_l.bit_cnt = 3'h1;
            next_l.slot = '0;
        end else begin
            next_l.bit_cnt = l.bit_cnt + 3'h1;
            if (l.bit_cnt == 3'h7) begin
                next_l.slot = l.slot + 5'h01;
            end
        end
        if (l.bit_cnt == 3'h7) begin
            if (l.slot == e1rse_pkg::ALIGN_SLOT) begin
                // bit 2 set marks the frame without the alignment word
                next_l.fas_frame = !word[7 - e1rse_pkg::SVC_SYNC_BIT];
                if (word[7 - e1rse_pkg::SVC_SYNC_BIT]) begin
                    // service word register keeps the non-alignment word only
                    next_l.ts0_word = word;
                    next_l.remote = word[5];
                    for (int k = 0; k < 5; k++) begin
                        next_l.spare_acc[16 * k + l.frame] = word[4 - k];
                        if (spare_sel_link[k]) begin
                            next_l.fifo_byte = {next_l.fifo_byte[6:0], word[4 - k]};
                            sel_idx = sel_idx + 6'h01;
                        end
                    end
                    next_l.fifo_cnt = l.fifo_cnt + 3'(sel_idx);
                    if ({1'b0, l.fifo_cnt} + 4'(sel_idx) >= 4'h8) begin
                        next_l.fifo_push = 1'b1;
                    end
                end
            end
            if (l.slot == e1rse_pkg::SIG_SLOT) begin
                next_l.ts16_word = word;
                next_l.frame = l.frame + 4'h1;
                if (word[7:4] == e1rse_pkg::MFAS_NIBBLE) begin
                    next_l.frame = 4'h1;
                    next_l.mf_err = '0;
                    next_l.x_bits = {word[3], word[1], word[0]};
                    next_l.remote = word[2];
                    if (!l.mf_sync || l.frame == 4'h0) begin
                        next_l.mf_sync = 1'b1;
                    end
                    next_l.mf_done = l.mf_sync;
                    next_l.ais = (l.ais_zeros <= e1rse_pkg::AIS_ZERO_MAX);
                    next_l.ais_zeros = 4'h0;
                end else begin
                    next_l.ais_zeros = l.ais_zeros + {3'h0, (word != 8'hff)};
                    next_l.mf_sig[4 * ({1'b0, l.frame} - 5'h1) +: 8] = word;
                    if (l.frame == 4'h0 && l.mf_sync) begin
                        next_l.mf_err = l.mf_err + 3'h1;
                        if (l.mf_err + 3'h1 >= e1rse_pkg::MFAS_LOSS_COUNT) begin
                            next_l.mf_sync = 1'b0;
                        end
                    end
                end
            end
        end
        // serial highway: forced first nibble, signaling in last nibble
        next_l.data_out = cfg_link[4] ? 1'b1 : in_bit;
        if (cfg_link[4]) begin
            next_l.sig_out = 1'b1;
        end else if (l.slot == e1rse_pkg::ALIGN_SLOT) begin
            next_l.sig_out = in_bit;
        end else if (l.slot == e1rse_pkg::SIG_SLOT) begin
            next_l.sig_out = (l.bit_cnt < e1rse_pkg::NIBBLE_SPLIT) ? 1'b0 : in_bit;
        end else if (l.bit_cnt < e1rse_pkg::NIBBLE_SPLIT) begin
            next_l.sig_out = (cfg_link[3:2] == e1rse_pkg::FILL_HIGH) ? 1'b1 :
                (cfg_link[3:2] == e1rse_pkg::FILL_LOW) ? 1'b0 : in_bit;
        end else begin
            // slot k carries signaling nibble k mod 16 from last multiframe
            next_l.sig_out = l.hw_sig[{l.slot[3:0], 2'h3 - l.bit_cnt[1:0]}];
        end
        if (next_l.mf_done) begin
            next_l.hw_sig = l.mf_sig;
        end
    end

    e1rse_sync #(.W(5)) u_sel_sync (
        .clk(system_rx_clock),
        .rst(link_rst),
        .d(spare_bit_select),
        .q(spare_sel_link)
    );

    always_ff @(posedge system_rx_clock) begin
        if (link_rst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // multiframe and fifo events cross by toggle; hw_sig holds for a multiframe, fifo_byte for two frames
    e1rse_event_sync u_mf_evt (
        .src_clk(system_rx_clock),
        .src_rst(link_rst),
        .src_pulse(l.mf_done),
        .dst_clk(core_clk),
        .dst_rst(rst),
        .dst_pulse(mf_done_core)
    );
    e1rse_event_sync u_fifo_evt (
        .src_clk(system_rx_clock),
        .src_rst(link_rst),
        .src_pulse(l.fifo_push),
        .dst_clk(core_clk),
        .dst_rst(rst),
        .dst_pulse(fifo_push_core)
    );
    e1rse_sync #(.W(5)) u_stat_sync (
        .clk(core_clk),
        .rst(rst),
        .d({!l.mf_sync, l.ais, l.remote, 2'h0}),
        .q(status_core)
    );
    e1rse_sync #(.W(3)) u_alarm_sync (
        .clk(core_clk),
        .rst(rst),
        .d({slip_positive, slip_negative, loss_of_signal_flag}),
        .q({slip_s, los_s})
    );

    always_comb begin
        logic cause;
        logic slip_now;
        cause = los_s | status_core[4] | c.slip_seen | slip_s[1] | slip_s[0];
        // a slip seen while auto-freeze is off must not freeze later
        slip_now = (slip_s[1] | slip_s[0]) & !auto_freeze_disable;
        next_c = c;
        next_c.ps_irq = 1'b0;
        next_c.ns_irq = 1'b0;
        next_c.chg_irq = 1'b0;
        next_c.rs_irq = 1'b0;
        next_c.fifo_valid = 1'b0;
        next_c.ps_irq = slip_s[1];
        next_c.ns_irq = slip_s[0];
        // slip held until a boundary so short slips still freeze
        next_c.slip_seen = c.slip_seen | slip_now;
        next_c.was_lost = status_core[4];
        if (!auto_freeze_disable && cause) begin
            next_c.freeze = 1'b1;
        end
        if (c.was_lost && !status_core[4]) begin
            next_c.rs_irq = 1'b1;
        end
        if (mf_done_core) begin
            next_c.slip_seen = slip_now;
            // release at boundary; this multiframe is still discarded
            if (!cause || auto_freeze_disable) begin
                next_c.freeze = 1'b0;
            end
            if (!c.freeze) begin
                next_c.regs = l.hw_sig;
                next_c.spare = l.spare_acc;
                next_c.svc = l.ts0_word;
                for (int i = 0; i < 16; i++) begin
                    next_c.ptr[i] = (l.hw_sig[4 * i +: 4] != c.regs[4 * i +: 4]);
                end
                next_c.chg_irq = (l.hw_sig != c.regs);
            end
        end
        if (fifo_push_core) begin
            next_c.fifo_data = l.fifo_byte;
            next_c.fifo_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            c <= '0;
            c.regs <= e1rse_pkg::SIG_RESET;
        end else begin
            c <= next_c;
        end
    end

    assign system_rx_data_out = l.data_out;
    assign sig_highway_out = l.sig_out;
    assign freeze_port = c.freeze;
    assign freeze_status_bit = c.freeze;
    assign sig_multiframe_align_lost = status_core[4];
    assign sig_ais_detect = status_core[3];
    assign sig_remote_alarm = status_core[2];
    assign sig_spare_x_bits = l.x_bits;
    assign rx_signaling_regs = c.regs;
    assign sig_change_pointer_regs = c.ptr;
    assign signaling_change_irq = c.chg_irq;
    assign resync_irq = c.rs_irq;
    assign positive_slip_irq = c.ps_irq;
    assign negative_slip_irq = c.ns_irq;
    assign rx_service_word_reg = c.svc;
    assign spare_bit_regs = c.spare;
    assign hdlc1_rx_fifo_data = c.fifo_data;
    assign hdlc1_rx_fifo_valid = c.fifo_valid;
endmodule : e1rse_top

// ### e1rse_pkg.sv
/*
 * e1rse_pkg: constants shared by the receive signaling extractor.
 * Assumes an E1 receive highway of 32 slots of 8 bits, msb (bit 1) first.
 */
package e1rse_pkg;
    localparam int unsigned SLOTS = 32;
    localparam int unsigned SLOT_BITS = 8;
    localparam int unsigned FRAME_BITS = 256;
    localparam int unsigned MF_FRAMES = 16;
    localparam logic [4:0] SIG_SLOT = 5'h10;
    localparam logic [4:0] ALIGN_SLOT = 5'h00;
    localparam logic [2:0] NIBBLE_SPLIT = 3'h4;
    localparam logic [3:0] MFAS_NIBBLE = 4'h0;
    localparam logic [1:0] PCFG_SIG_HIGHWAY = 2'h1;
    localparam logic [1:0] FILL_HIGH = 2'h1;
    localparam logic [1:0] FILL_LOW = 2'h2;
    localparam logic [2:0] SVC_SYNC_BIT = 3'h1;
    localparam logic [2:0] SPARE_FIRST_BIT = 3'h3;
    localparam logic [2:0] MFAS_LOSS_COUNT = 3'h2;
    localparam logic [3:0] AIS_ZERO_MAX = 4'h2;
    localparam logic [63:0] SIG_RESET = 64'hffffffffffffffff;
endpackage : e1rse_pkg

// ### e1rse_sync.sv
/*
 * e1rse_sync: two-flop level synchroniser.
 * Assumes the input is a slow level from another clock domain or a pin.
 */
`timescale 1ns/1ps
module e1rse_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } e1rse_sync_t;
    e1rse_sync_t r;
    e1rse_sync_t next_r;

    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule : e1rse_sync

// ### e1rse_event_sync.sv
/*
 * e1rse_event_sync: carries a one-cycle pulse from the link clock to core_clk
 * by a toggle and a two-flop synchroniser.
 * Assumes pulses on the source side are at least a few core cycles apart.
 */
`timescale 1ns/1ps
module e1rse_event_sync (
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_pulse,
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_pulse
);
    typedef struct packed {
        logic tog;
    } e1rse_evs_src_t;
    typedef struct packed {
        logic last;
    } e1rse_evs_dst_t;
    e1rse_evs_src_t s;
    e1rse_evs_src_t next_s;
    e1rse_evs_dst_t d;
    e1rse_evs_dst_t next_d;
    logic tog_sync;

    always_comb begin
        next_s.tog = s.tog ^ src_pulse;
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    e1rse_sync #(.W(1)) u_sync (
        .clk(dst_clk),
        .rst(dst_rst),
        .d(s.tog),
        .q(tog_sync)
    );

    always_comb begin
        next_d.last = tog_sync;
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            d <= '0;
        end else begin
            d <= next_d;
        end
    end

    assign dst_pulse = tog_sync ^ d.last;
endmodule : e1rse_event_sync

// ### e1rse_src.sv
/*
 * e1rse_src: far-end highway source with 256-bit frames, 16-frame multiframes
 * and a sync pulse on bit 1 of slot 0.
 * Assumes a free-running highway clock from the bench; changes at its fall.
 */
`timescale 1ns/1ps
module e1rse_src (
    input wire logic clk,
    input wire logic [7:0] line_sig,
    input wire logic [7:0] sys_sig,
    output logic sync,
    output logic line_bit,
    output logic sys_bit
);
    logic [7:0] bitn = 8'h00;
    logic [3:0] frm = 4'h0;
    logic [7:0] lb;
    logic [7:0] sb;

    function automatic logic [7:0] slot_byte(input logic [7:0] s, input logic [7:0] b,
                                             input logic [3:0] f);
        if (b[7:3] == e1rse_pkg::ALIGN_SLOT)
            slot_byte = f[0] ? 8'hdf : 8'h9b;
        else if (b[7:3] == e1rse_pkg::SIG_SLOT)
            slot_byte = (f == 4'h0) ? {e1rse_pkg::MFAS_NIBBLE, s[3:0]} : s;
        else
            slot_byte = {3'h5, b[7:3]};
    endfunction : slot_byte

    assign lb = slot_byte(line_sig, bitn, frm);
    assign sb = slot_byte(sys_sig, bitn, frm);

    initial begin
        sync = 1'b0;
        line_bit = 1'b1;
        sys_bit = 1'b1;
    end

    // msb first, 32 slots of 8 bits
    always @(negedge clk) begin
        sync <= (bitn == 8'h00);
        line_bit <= lb[3'h7 - bitn[2:0]];
        sys_bit <= sb[3'h7 - bitn[2:0]];
        bitn <= bitn + 8'h01;
        if (bitn == 8'hff)
            frm <= frm + 4'h1;
    end
endmodule : e1rse_src

// ### e1rse_sva.sv
/*
 * e1rse_sva: port assertions on freeze, slips and change reporting.
 * Assumes the bench holds control levels for many core cycles.
 */
`timescale 1ns/1ps
module e1rse_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic auto_freeze_disable,
    input wire logic loss_of_signal_flag,
    input wire logic slip_positive,
    input wire logic slip_negative,
    input wire logic freeze_port,
    input wire logic freeze_status_bit,
    input wire logic [63:0] rx_signaling_regs,
    input wire logic [15:0] sig_change_pointer_regs,
    input wire logic signaling_change_irq,
    input wire logic positive_slip_irq,
    input wire logic negative_slip_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence pos_slip_s;
        $rose(slip_positive) ##0 !auto_freeze_disable;
    endsequence
    sequence neg_slip_s;
        $rose(slip_negative) ##0 !auto_freeze_disable;
    endsequence
    sequence frozen_s;
        ##[1:8] freeze_status_bit;
    endsequence

    AST_FREEZE_MIRROR: assert property (freeze_port == freeze_status_bit)
        else $error("freeze port and status differ");
    AST_LOS_FREEZE: assert property ($rose(loss_of_signal_flag) && !auto_freeze_disable |-> frozen_s)
        else $error("no freeze after loss of signal");
    AST_PSLIP_FREEZE: assert property (pos_slip_s |-> frozen_s)
        else $error("no freeze after positive slip");
    AST_NSLIP_FREEZE: assert property (neg_slip_s |-> frozen_s)
        else $error("no freeze after negative slip");
    AST_PSLIP_IRQ: assert property ($rose(slip_positive) |-> ##[1:8] positive_slip_irq)
        else $error("positive slip not reported");
    AST_NSLIP_IRQ: assert property ($rose(slip_negative) |-> ##[1:8] negative_slip_irq)
        else $error("negative slip not reported");
    AST_NO_AUTO_FREEZE: assert property (auto_freeze_disable && $past(auto_freeze_disable) |-> !$rose(freeze_status_bit))
        else $error("freeze rose while disabled");
    AST_FROZEN_HOLD: assert property (freeze_status_bit |=> $stable(rx_signaling_regs))
        else $error("signaling changed while frozen");
    AST_CHG_PTR: assert property (signaling_change_irq |-> ##[0:2] (sig_change_pointer_regs != 16'h0000))
        else $error("change without pointer");
    AST_CHG_PULSE: assert property (signaling_change_irq |=> !signaling_change_irq)
        else $error("change pulse too long");
endmodule : e1rse_sva

bind e1rse_top e1rse_sva chk_u (.core_clk, .rst, .auto_freeze_disable, .loss_of_signal_flag,
    .slip_positive, .slip_negative, .freeze_port, .freeze_status_bit, .rx_signaling_regs,
    .sig_change_pointer_regs, .signaling_change_irq, .positive_slip_irq, .negative_slip_irq);

// ### tb_top.sv
/*
 * tb_top: self-checking bench for e1rse_top fed by e1rse_src.
 * Assumes alignment and first storage within a few multiframes.
 */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic los, sp, sn, daf, frz, pirq, nirq;
    } e1rse_row_t;
    logic core_clk = 1'b0, system_rx_clock = 1'b0, rst = 1'b1, link_rst = 1'b1;
    logic system_rx_sync_pulse, line_data, system_side_data;
    logic [1:0] port_function_cfg = 2'h0, sig_upper_nibble_fill = 2'h0;
    logic ext_signaling_enable = 1'b0, send_all_ones_system = 1'b0;
    logic auto_freeze_disable = 1'b0, loss_of_signal_flag = 1'b0;
    logic slip_positive = 1'b0, slip_negative = 1'b0;
    logic [4:0] spare_bit_select = 5'h1f;
    logic [7:0] line_sig = 8'hbb, sys_sig = 8'h33;
    logic system_rx_data_out, sig_highway_out, freeze_port, freeze_status_bit;
    logic sig_multiframe_align_lost, sig_ais_detect, sig_remote_alarm;
    logic signaling_change_irq, resync_irq, positive_slip_irq, negative_slip_irq;
    logic hdlc1_rx_fifo_valid;
    logic [2:0] sig_spare_x_bits;
    logic [63:0] rx_signaling_regs;
    logic [15:0] sig_change_pointer_regs;
    logic [7:0] rx_service_word_reg, hdlc1_rx_fifo_data;
    logic [79:0] spare_bit_regs;
    int err_total = 0, cmp_count = 0, cyc = 0, chg_seen = 0, fifo_n = 0, rs_seen = 0;
    // los sp sn daf | freeze pirq nirq
    e1rse_row_t rows [6] = '{7'b1001000, 7'b0101010, 7'b0011001,
                             7'b1000100, 7'b0100110, 7'b0010101};

    e1rse_top dut_u (.core_clk, .rst, .system_rx_clock, .link_rst, .system_rx_sync_pulse,
        .line_data, .system_side_data, .port_function_cfg, .ext_signaling_enable,
        .sig_upper_nibble_fill, .send_all_ones_system, .auto_freeze_disable,
        .loss_of_signal_flag, .slip_positive, .slip_negative, .spare_bit_select,
        .system_rx_data_out, .sig_highway_out, .freeze_port, .freeze_status_bit,
        .sig_multiframe_align_lost, .sig_ais_detect, .sig_remote_alarm, .sig_spare_x_bits,
        .rx_signaling_regs, .sig_change_pointer_regs, .signaling_change_irq, .resync_irq,
        .positive_slip_irq, .negative_slip_irq, .rx_service_word_reg, .spare_bit_regs,
        .hdlc1_rx_fifo_data, .hdlc1_rx_fifo_valid);
    e1rse_src src_u (.clk(system_rx_clock), .line_sig, .sys_sig,
        .sync(system_rx_sync_pulse), .line_bit(line_data), .sys_bit(system_side_data));

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial forever #2 core_clk = ~core_clk;
    // phase offset keeps the edges of the two clocks apart
    initial begin
        #11;
        forever #32 system_rx_clock = ~system_rx_clock;
    end
    initial begin
        repeat (6) @(negedge system_rx_clock);
        link_rst = 1'b0;
    end

    // sampled at the fall so registered pulses have settled
    always @(negedge core_clk) begin
        cyc++;
        if (signaling_change_irq === 1'b1)
            chg_seen++;
        if (resync_irq === 1'b1)
            rs_seen++;
        if (hdlc1_rx_fifo_valid === 1'b1) begin
            fifo_n++;
            check(hdlc1_rx_fifo_data, 8'hff);
        end
        if (cyc == 900000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        int i;
        int c0;
        logic ps, ns, ones, zero;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        // first stored multiframe after alignment and release
        for (i = 0; i < 400000 && chg_seen == 0; i++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        check(rx_signaling_regs, {16{4'hb}});
        check(sig_change_pointer_regs, 16'hffff);
        check({freeze_status_bit, sig_multiframe_align_lost}, 2'b00);
        check({sig_ais_detect, sig_remote_alarm, sig_spare_x_bits}, 5'b00111);
        // spare bits exist only in the odd, non-alignment frames
        check(spare_bit_regs, {5{16'haaaa}});
        check(rx_service_word_reg, 8'hdf);
        check(rs_seen, 1);
        c0 = chg_seen;
        repeat (70000) @(negedge core_clk);
        check(chg_seen, c0);
        port_function_cfg = e1rse_pkg::PCFG_SIG_HIGHWAY;
        ext_signaling_enable = 1'b1;
        // mixed multiframe first, then a clean system-side one
        for (i = 0; i < 150000 && chg_seen < c0 + 2; i++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        check(rx_signaling_regs, {16{4'h3}});
        check(fifo_n != 0, 1'b1);
        foreach (rows[r]) begin
            {loss_of_signal_flag, slip_positive, slip_negative, auto_freeze_disable} = rows[r][6:3];
            ps = 1'b0;
            ns = 1'b0;
            for (i = 0; i < 16; i++) begin
                @(negedge core_clk);
                ps = ps | positive_slip_irq;
                ns = ns | negative_slip_irq;
                if (i == 4)
                    {loss_of_signal_flag, slip_positive, slip_negative} = 3'b000;
            end
            check({freeze_status_bit, ps, ns}, rows[r][2:0]);
            auto_freeze_disable = 1'b0;
            repeat (4) @(negedge core_clk);
        end
        for (i = 0; i < 150000 && freeze_status_bit !== 1'b0; i++) @(negedge core_clk);
        check(freeze_status_bit, 1'b0);
        send_all_ones_system = 1'b1;
        sig_upper_nibble_fill = e1rse_pkg::FILL_LOW;
        repeat (12) @(negedge system_rx_clock);
        ones = 1'b1;
        repeat (256) begin
            @(negedge system_rx_clock);
            ones = ones & system_rx_data_out & sig_highway_out;
        end
        check(ones, 1'b1);
        send_all_ones_system = 1'b0;
        repeat (12) @(negedge system_rx_clock);
        zero = 1'b0;
        repeat (256) begin
            @(negedge system_rx_clock);
            zero = zero | !sig_highway_out;
        end
        check(zero, 1'b1);
        report_and_stop();
    end
endmodule : tb_top
